/* core/brc_map.vh */
// constants for the burst level select, active burst and auto-restart controller
`ifndef BRC_MAP_VH
`define BRC_MAP_VH
`define BRC_CLK_MHZ 125
`define BRC_DET_WIN_US 1000
`define BRC_BLANK_US 20000
`define BRC_ADDR_W 12
`define BRC_CTRL_OFS 12'h000
`define BRC_STAT_OFS 12'h004
`define BRC_CNT_OFS 12'h008
`define BRC_CTRL_RST 1'b1
`define BRC_RESP_OK 2'b00
`define BRC_RESP_ERR 2'b10
`define BRC_LVL_160 2'h0
`define BRC_LVL_142 2'h1
`define BRC_LVL_127 2'h2
`define BRC_LVL_NONE 2'h3
`define BRC_CNT_LVL1 8'h04
`define BRC_CNT_LVL2 8'h18
`define BRC_CNT_LVL3 8'h78
`define BRC_MODE_NONE 2'h0
`define BRC_MODE_NORM 2'h1
`define BRC_MODE_ODD 2'h2
`define BRC_MODE_NSW 2'h3
`endif

/* core/brc_core.v */
// burst level select, active burst and auto-restart sequencing with axi4-lite registers
`timescale 1ns/1ps
`include "brc_map.vh"

module brc_core
#(
   parameter CNT_W = 22,
   parameter DET_CYC = `BRC_DET_WIN_US * `BRC_CLK_MHZ,
   parameter BLANK_CYC = `BRC_BLANK_US * `BRC_CLK_MHZ,
   parameter [7:0] CNT_LVL1 = `BRC_CNT_LVL1,
   parameter [7:0] CNT_LVL2 = `BRC_CNT_LVL2,
   parameter [7:0] CNT_LVL3 = `BRC_CNT_LVL3
)
(
   // clock and reset
   input wire MCLK,
   input wire RST_N,
   // feedback pin comparators
   input wire FB_ABOVE_4V5,
   input wire FB_BELOW_0V5,
   input wire FB_BELOW_ENTRY,
   input wire FB_ABOVE_3V5,
   input wire FB_BELOW_3V2,
   input wire FB_ABOVE_4V0,
   // supply and fault detectors
   input wire UVLO_ON,
   input wire VCC_OVP1,
   input wire VCC_OVP2,
   input wire OVER_TEMP,
   input wire EXT_PROT,
   input wire BROWNOUT,
   // analog and gate controls
   output reg DETECT_DISCHARGE_SWITCH,
   output reg [1:0] ENTRY_SEL,
   output reg BURST_CS_SEL,
   output reg BIAS_EN,
   output reg GATE_EN,
   output reg AR_ACTIVE,
   // axi4-lite write
   input wire [`BRC_ADDR_W-1:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // axi4-lite read
   input wire [`BRC_ADDR_W-1:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY
);

////////////////////////////////////////////////////////////////////////////////
localparam NI = 12;
localparam [1:0] S_OFF = 2'h0;
localparam [1:0] S_DET = 2'h1;
localparam [1:0] S_RUN = 2'h2;
localparam [1:0] S_AR = 2'h3;
localparam integer DET_M1 = DET_CYC - 1;
localparam integer BLANK_M1 = BLANK_CYC - 1;
localparam [CNT_W-1:0] DET_LIM = DET_M1[CNT_W-1:0];
localparam [CNT_W-1:0] BLANK_LIM = BLANK_M1[CNT_W-1:0];
localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser: comparators are asynchronous to MCLK
wire [NI-1:0] pin_raw;
reg [NI-1:0] sync1_q;
reg [NI-1:0] sync2_q;

assign pin_raw = {FB_ABOVE_4V5, FB_BELOW_0V5, FB_BELOW_ENTRY, FB_ABOVE_3V5,
   FB_BELOW_3V2, FB_ABOVE_4V0, UVLO_ON, VCC_OVP1,
   VCC_OVP2, OVER_TEMP, EXT_PROT, BROWNOUT};

always @(posedge MCLK or negedge RST_N)
begin
   if (!RST_N)
   begin
      sync1_q <= {NI{1'b0}};
      sync2_q <= {NI{1'b0}};
   end
   else
   begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
   end
end

wire fb45 = sync2_q[11];
wire fb05 = sync2_q[10];
wire fb_entry = sync2_q[9];
wire fb35 = sync2_q[8];
wire fb32 = sync2_q[7];
wire fb40 = sync2_q[6];
wire uvlo = sync2_q[5];
wire ovp1 = sync2_q[4];
wire ovp2 = sync2_q[3];
wire otp = sync2_q[2];
wire ext_prot = sync2_q[1];
wire brown = sync2_q[0];

////////////////////////////////////////////////////////////////////////////////
// control state
reg [1:0] st_q;
reg [1:0] st_d;
reg done_q;
reg done_d;
reg [1:0] lvl_q;
reg [1:0] lvl_d;
reg detect_phase_flag_q;
reg detect_phase_flag_d;
reg [7:0] dcnt_q;
reg [7:0] dcnt_d;
reg [CNT_W-1:0] tmr_q;
reg [CNT_W-1:0] tmr_d;
reg [CNT_W-1:0] bcnt_q;
reg [CNT_W-1:0] bcnt_d;
reg [CNT_W-1:0] ocnt_q;
reg [CNT_W-1:0] ocnt_d;
reg burst_q;
reg burst_d;
reg bias_q;
reg bias_d;
reg [1:0] mode_q;
reg [1:0] mode_d;
reg par_q;
reg par_d;
reg uvlo_prev_q;
reg burst_allow_q;
reg ar_go;
wire uvlo_rise = uvlo & ~uvlo_prev_q;
wire nsw_fault = otp | ext_prot;
wire odd_fault = ovp2 | (ovp1 & fb45) | (ocnt_q == BLANK_LIM);

always @*
begin
   st_d = st_q;
   done_d = done_q;
   lvl_d = lvl_q;
   detect_phase_flag_d = detect_phase_flag_q;
   dcnt_d = dcnt_q;
   tmr_d = tmr_q;
   bcnt_d = bcnt_q;
   burst_d = burst_q;
   bias_d = bias_q;
   mode_d = mode_q;
   par_d = par_q;
   ar_go = 1'b0;
   ocnt_d = {CNT_W{1'b0}};
   if (st_q == S_RUN && fb45)
      ocnt_d = ocnt_q + CNT_ONE;
   case (st_q)
      S_OFF:
      begin
         if (uvlo)
         begin
            if (done_q)
               st_d = S_RUN;
            else if (!(ext_prot | brown))
            begin
               st_d = S_DET;
               tmr_d = {CNT_W{1'b0}};
               dcnt_d = 8'h00;
               detect_phase_flag_d = 1'b0;
            end
         end
      end
      S_DET:
      begin
         tmr_d = tmr_q + CNT_ONE;
         if (!detect_phase_flag_q && fb45)
         begin
            detect_phase_flag_d = 1'b1;
            if (dcnt_q != 8'hff)
               dcnt_d = dcnt_q + 8'h01;
         end
         else if (detect_phase_flag_q && fb05)
            detect_phase_flag_d = 1'b0;
         if (!uvlo)
         begin
            // supply lost before the window closed: detect again next time
            st_d = S_OFF;
            detect_phase_flag_d = 1'b0;
         end
         else if (tmr_q == DET_LIM)
         begin
            // bigger capacitor charges slower, so fewer cycles fit the window
            if (dcnt_q < CNT_LVL1)
               lvl_d = `BRC_LVL_160;
            else if (dcnt_q < CNT_LVL2)
               lvl_d = `BRC_LVL_142;
            else if (dcnt_q < CNT_LVL3)
               lvl_d = `BRC_LVL_127;
            else
               lvl_d = `BRC_LVL_NONE;
            done_d = 1'b1;
            detect_phase_flag_d = 1'b0;
            st_d = S_RUN;
         end
      end
      S_RUN:
      begin
         if (!burst_q)
         begin
            bias_d = 1'b1;
            if (fb_entry && lvl_q != `BRC_LVL_NONE && burst_allow_q)
            begin
               bcnt_d = bcnt_q + CNT_ONE;
               if (bcnt_q == BLANK_LIM)
               begin
                  burst_d = 1'b1;
                  bias_d = 1'b0;
                  bcnt_d = {CNT_W{1'b0}};
               end
            end
            else
               bcnt_d = {CNT_W{1'b0}};
         end
         else if (fb40)
         begin
            burst_d = 1'b0;
            bias_d = 1'b1;
            bcnt_d = {CNT_W{1'b0}};
         end
         else if (fb35)
            bias_d = 1'b1;
         else if (fb32)
            bias_d = 1'b0;
         if (nsw_fault)
         begin
            mode_d = `BRC_MODE_NSW;
            ar_go = 1'b1;
         end
         else if (odd_fault)
         begin
            mode_d = `BRC_MODE_ODD;
            ar_go = 1'b1;
         end
         else if (!uvlo)
         begin
            mode_d = `BRC_MODE_NORM;
            ar_go = 1'b1;
         end
         if (ar_go)
         begin
            st_d = S_AR;
            par_d = 1'b0;
            burst_d = 1'b0;
            bcnt_d = {CNT_W{1'b0}};
            bias_d = 1'b1;
         end
      end
      S_AR:
      begin
         if (uvlo_rise)
         begin
            par_d = ~par_q;
            if (mode_q == `BRC_MODE_NORM)
               st_d = S_RUN;
            else if (par_q)
            begin
               // the cycle now starting is even
               if (mode_q == `BRC_MODE_ODD)
                  st_d = S_RUN;
               else if (!nsw_fault)
                  st_d = S_RUN;
            end
         end
      end
      default:
         st_d = S_OFF;
   endcase
end

always @(posedge MCLK or negedge RST_N)
begin
   if (!RST_N)
   begin
      st_q <= S_OFF;
      done_q <= 1'b0;
      lvl_q <= `BRC_LVL_NONE;
      detect_phase_flag_q <= 1'b0;
      dcnt_q <= 8'h00;
      tmr_q <= {CNT_W{1'b0}};
      bcnt_q <= {CNT_W{1'b0}};
      ocnt_q <= {CNT_W{1'b0}};
      burst_q <= 1'b0;
      bias_q <= 1'b1;
      mode_q <= `BRC_MODE_NONE;
      par_q <= 1'b0;
      uvlo_prev_q <= 1'b0;
   end
   else
   begin
      st_q <= st_d;
      done_q <= done_d;
      lvl_q <= lvl_d;
      detect_phase_flag_q <= detect_phase_flag_d;
      dcnt_q <= dcnt_d;
      tmr_q <= tmr_d;
      bcnt_q <= bcnt_d;
      ocnt_q <= ocnt_d;
      burst_q <= burst_d;
      bias_q <= bias_d;
      mode_q <= mode_d;
      par_q <= par_d;
      uvlo_prev_q <= uvlo;
   end
end

////////////////////////////////////////////////////////////////////////////////
// outputs, one cycle behind the state; the comparators are far slower anyway
always @(posedge MCLK or negedge RST_N)
begin
   if (!RST_N)
   begin
      DETECT_DISCHARGE_SWITCH <= 1'b0;
      ENTRY_SEL <= `BRC_LVL_NONE;
      BURST_CS_SEL <= 1'b0;
      BIAS_EN <= 1'b0;
      GATE_EN <= 1'b0;
      AR_ACTIVE <= 1'b0;
   end
   else
   begin
      DETECT_DISCHARGE_SWITCH <= detect_phase_flag_q;
      ENTRY_SEL <= lvl_q;
      BURST_CS_SEL <= burst_q;
      BIAS_EN <= bias_q & (st_q == S_RUN);
      GATE_EN <= bias_q & (st_q == S_RUN);
      AR_ACTIVE <= (st_q == S_AR);
   end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave; address and data taken in either order
reg aw_got_q;
reg w_got_q;
reg [`BRC_ADDR_W-1:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg [31:0] rd_mux;
reg rd_hit;
wire wr_go = aw_got_q & w_got_q & ~S_AXI_BVALID;
wire [`BRC_ADDR_W-1:0] wa = {awaddr_q[`BRC_ADDR_W-1:2], 2'b00};
wire [`BRC_ADDR_W-1:0] ra = {S_AXI_ARADDR[`BRC_ADDR_W-1:2], 2'b00};
wire wr_hit = (wa == `BRC_CTRL_OFS) | (wa == `BRC_STAT_OFS) | (wa == `BRC_CNT_OFS);

always @*
begin
   rd_hit = 1'b1;
   case (ra)
      `BRC_CTRL_OFS:
         rd_mux = {31'h0, burst_allow_q};
      `BRC_STAT_OFS:
         rd_mux = {22'h0, st_q, par_q, mode_q, bias_q, burst_q, done_q, lvl_q};
      `BRC_CNT_OFS:
         rd_mux = {24'h0, dcnt_q};
      default:
      begin
         rd_mux = 32'h0;
         rd_hit = 1'b0;
      end
   endcase
end

always @(posedge MCLK or negedge RST_N)
begin
   if (!RST_N)
   begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `BRC_RESP_OK;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= {`BRC_ADDR_W{1'b0}};
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      burst_allow_q <= `BRC_CTRL_RST;
   end
   else
   begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         S_AXI_AWREADY <= 1'b0;
         aw_got_q <= 1'b1;
         awaddr_q <= S_AXI_AWADDR;
      end
      else if (!aw_got_q)
         S_AXI_AWREADY <= 1'b1;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         S_AXI_WREADY <= 1'b0;
         w_got_q <= 1'b1;
         wdata_q <= S_AXI_WDATA;
         wstrb_q <= S_AXI_WSTRB;
      end
      else if (!w_got_q)
         S_AXI_WREADY <= 1'b1;
      if (wr_go)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= wr_hit ? `BRC_RESP_OK : `BRC_RESP_ERR;
         // status and count words ignore writes
         if (wa == `BRC_CTRL_OFS && wstrb_q[0])
            burst_allow_q <= wdata_q[0];
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
         S_AXI_BVALID <= 1'b0;
   end
end

always @(posedge MCLK or negedge RST_N)
begin
   if (!RST_N)
   begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `BRC_RESP_OK;
   end
   else if (S_AXI_ARVALID && S_AXI_ARREADY)
   begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= rd_hit ? `BRC_RESP_OK : `BRC_RESP_ERR;
   end
   else if (S_AXI_RVALID)
   begin
      if (S_AXI_RREADY)
         S_AXI_RVALID <= 1'b0;
   end
   else
      S_AXI_ARREADY <= 1'b1;
end

endmodule

/* verification/brc_fb_model.sv */
// behavioural feedback pin and its comparators for the burst and restart bench
`timescale 1ns/1ps
module brc_fb_model
(
   // block side
   input wire logic MCLK,
   input wire logic DETECT_DISCHARGE_SWITCH,
   input wire logic [1:0] ENTRY_SEL,
   // operating point in millivolts from the bench
   input wire logic det,
   input wire logic [31:0] rate,
   input wire logic [31:0] fb_mv,
   // comparators
   output logic FB_ABOVE_4V5,
   output logic FB_BELOW_0V5,
   output logic FB_BELOW_ENTRY,
   output logic FB_ABOVE_3V5,
   output logic FB_BELOW_3V2,
   output logic FB_ABOVE_4V0
);
   logic [31:0] v = 32'h0;
   logic [31:0] thr;
   ////////////////////////////////////////
   // pin charges by rate each cycle toward the 5v source; the small discharge resistor empties it at once
   always @(posedge MCLK)
      v <= !det ? fb_mv : DETECT_DISCHARGE_SWITCH ? 32'h0 : (v + rate > 5000 ? 5000 : v + rate);
   // the never level still trips the comparator at the lowest threshold; only the logic may refuse burst
   assign thr = ENTRY_SEL == 2'h0 ? 1600 : ENTRY_SEL == 2'h1 ? 1420 : 1270;
   assign FB_BELOW_ENTRY = v < thr;
   assign FB_ABOVE_4V5 = v > 4500;
   assign FB_BELOW_0V5 = v < 500;
   assign FB_ABOVE_3V5 = v > 3500;
   assign FB_BELOW_3V2 = v <= 3200;
   assign FB_ABOVE_4V0 = v > 4000;
endmodule

/* verification/brc_core_asserts.sv */
// assertion checker for the burst and restart controller ports
`timescale 1ns/1ps
module brc_core_asserts #(parameter BLANK_CYC = 2500000)
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // comparators and faults
   input wire logic FB_ABOVE_4V5,
   input wire logic FB_BELOW_0V5,
   input wire logic FB_BELOW_ENTRY,
   input wire logic FB_ABOVE_3V5,
   input wire logic FB_BELOW_3V2,
   input wire logic FB_ABOVE_4V0,
   input wire logic OVER_TEMP,
   input wire logic EXT_PROT,
   // controls
   input wire logic DETECT_DISCHARGE_SWITCH,
   input wire logic [1:0] ENTRY_SEL,
   input wire logic BURST_CS_SEL,
   input wire logic BIAS_EN,
   input wire logic GATE_EN,
   input wire logic AR_ACTIVE
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);
   logic [31:0] lo_cnt_q;
   logic [31:0] hi_cnt_q;
   ////////////////////////////////////////
   // raw run lengths; the sync stages only add slack to them; overload only counts while switching
   always @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         lo_cnt_q <= 32'h0;
         hi_cnt_q <= 32'h0;
      end
      else
      begin
         lo_cnt_q <= FB_BELOW_ENTRY ? lo_cnt_q + 32'h1 : 32'h0;
         hi_cnt_q <= (FB_ABOVE_4V5 && GATE_EN) ? hi_cnt_q + 32'h1 : 32'h0;
      end
   end
   ////////////////////////////////////////
   a_burst_blank: assert property ($rose(BURST_CS_SEL) |-> lo_cnt_q >= BLANK_CYC && ENTRY_SEL != 2'h3)
      else $error("burst entered before blanking ran out");
   a_overload_blank: assert property (hi_cnt_q == BLANK_CYC |-> ##[1:6] AR_ACTIVE)
      else $error("overload did not start restart");
   a_detect_set: assert property ($rose(DETECT_DISCHARGE_SWITCH) |-> $past(FB_ABOVE_4V5, 2))
      else $error("discharge switch closed without high pin");
   a_detect_clear: assert property ($fell(DETECT_DISCHARGE_SWITCH) |-> $past(FB_BELOW_0V5, 2) || $rose(GATE_EN))
      else $error("discharge switch opened without low pin");
   a_gate_bias: assert property (GATE_EN |-> BIAS_EN && !AR_ACTIVE && !DETECT_DISCHARGE_SWITCH)
      else $error("switching without bias or during restart");
   a_bias_on: assert property (BURST_CS_SEL && FB_ABOVE_3V5 && !FB_ABOVE_4V0 |-> ##[1:6] BIAS_EN && GATE_EN)
      else $error("bias not restored in burst");
   a_bias_off: assert property (BURST_CS_SEL && FB_BELOW_3V2 |-> ##[1:6] !BIAS_EN)
      else $error("bias not removed in burst");
   a_burst_exit: assert property (BURST_CS_SEL && FB_ABOVE_4V0 |-> ##[1:6] !BURST_CS_SEL && GATE_EN)
      else $error("burst not left on high feedback");
   a_nosw_hold: assert property (AR_ACTIVE && (OVER_TEMP || EXT_PROT) |=> AR_ACTIVE)
      else $error("restart left while fault present");
   a_level_hold: assert property (AR_ACTIVE || BURST_CS_SEL |-> $stable(ENTRY_SEL))
      else $error("level changed after selection");
endmodule
bind brc_core brc_core_asserts #(.BLANK_CYC(BLANK_CYC)) u_brc_core_asserts
(
   .MCLK(MCLK),
   .RST_N(RST_N),
   .FB_ABOVE_4V5(FB_ABOVE_4V5),
   .FB_BELOW_0V5(FB_BELOW_0V5),
   .FB_BELOW_ENTRY(FB_BELOW_ENTRY),
   .FB_ABOVE_3V5(FB_ABOVE_3V5),
   .FB_BELOW_3V2(FB_BELOW_3V2),
   .FB_ABOVE_4V0(FB_ABOVE_4V0),
   .OVER_TEMP(OVER_TEMP),
   .EXT_PROT(EXT_PROT),
   .DETECT_DISCHARGE_SWITCH(DETECT_DISCHARGE_SWITCH),
   .ENTRY_SEL(ENTRY_SEL),
   .BURST_CS_SEL(BURST_CS_SEL),
   .BIAS_EN(BIAS_EN),
   .GATE_EN(GATE_EN),
   .AR_ACTIVE(AR_ACTIVE)
);

/* verification/brc_core_tb.sv */
// self-checking bench for the burst and restart controller
`timescale 1ns/1ps
`include "brc_map.vh"
module brc_core_tb;
   localparam int DET = 3000;
   localparam int BLK = 500;
   logic MCLK = 1'h0;
   logic RST_N = 1'h0;
   logic UVLO_ON = 1'h0;
   logic VCC_OVP1 = 1'h0;
   logic VCC_OVP2 = 1'h0;
   logic OVER_TEMP = 1'h0;
   logic EXT_PROT = 1'h0;
   logic BROWNOUT = 1'h0;
   logic FB_ABOVE_4V5, FB_BELOW_0V5, FB_BELOW_ENTRY, FB_ABOVE_3V5, FB_BELOW_3V2, FB_ABOVE_4V0;
   logic DETECT_DISCHARGE_SWITCH, BURST_CS_SEL, BIAS_EN, GATE_EN, AR_ACTIVE;
   logic [1:0] ENTRY_SEL, S_AXI_BRESP, S_AXI_RRESP, resp_q;
   logic [`BRC_ADDR_W-1:0] S_AXI_AWADDR = 12'h0;
   logic [`BRC_ADDR_W-1:0] S_AXI_ARADDR = 12'h0;
   logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
   logic [31:0] S_AXI_WDATA = 32'h0;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [31:0] S_AXI_RDATA, rd_q;
   logic det = 1'h0;
   logic [31:0] rate = 32'h0;
   logic [31:0] fb_mv = 32'h0;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int rate_t [4] = '{4, 30, 150, 4600};
   int lo_t [4] = '{0, `BRC_CNT_LVL1, `BRC_CNT_LVL2, `BRC_CNT_LVL3};
   int hi_t [4] = '{`BRC_CNT_LVL1 - 1, `BRC_CNT_LVL2 - 1, `BRC_CNT_LVL3 - 1, 255};
   // short windows keep the run small; the window-length waits below are derived from them
   brc_core #(.DET_CYC(DET), .BLANK_CYC(BLK)) u_brc_core (.*);
   brc_fb_model u_brc_fb_model (.*);
   always #4 MCLK = ~MCLK;
   ////////////////////////////////////////
   task test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge MCLK)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         errors++;
         test_done;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge MCLK);
   endtask
   task fb(input int mv);
      det <= 1'h0;
      fb_mv <= mv;
   endtask
   // both channels offered together, each dropped at its own handshake
   task axi_wr(input logic [11:0] a, input logic [31:0] d);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID <= 1'h1;
      S_AXI_BREADY <= 1'h1;
      @(posedge MCLK);
      while (S_AXI_AWVALID || S_AXI_WVALID)
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
            S_AXI_AWVALID <= 1'h0;
         if (S_AXI_WVALID && S_AXI_WREADY)
            S_AXI_WVALID <= 1'h0;
         @(posedge MCLK);
      end
      while (!S_AXI_BVALID) @(posedge MCLK);
      resp_q = S_AXI_BRESP;
      S_AXI_BREADY <= 1'h0;
      tick(1);
   endtask
   task axi_rd(input logic [11:0] a);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'h1;
      S_AXI_RREADY <= 1'h1;
      @(posedge MCLK);
      while (!S_AXI_ARREADY) @(posedge MCLK);
      S_AXI_ARVALID <= 1'h0;
      @(posedge MCLK);
      while (!S_AXI_RVALID) @(posedge MCLK);
      rd_q = S_AXI_RDATA;
      resp_q = S_AXI_RRESP;
      S_AXI_RREADY <= 1'h0;
      tick(1);
   endtask
   // fresh power-up: reset, supply on, detection window with the given pin ramp
   task start(input int r);
      RST_N <= 1'h0;
      UVLO_ON <= 1'h0;
      fb(0);
      tick(10);
      RST_N <= 1'h1;
      rate <= r;
      tick(2);
      det <= 1'h1;
      UVLO_ON <= 1'h1;
      tick(DET + 20);
   endtask
   task uv;
      UVLO_ON <= 1'h0;
      tick(10);
      UVLO_ON <= 1'h1;
      tick(10);
   endtask
   ////////////////////////////////////////
   task t_levels;
      for (int i = 0; i < 4; i++)
      begin
         start(rate_t[i]);
         fb(2500);
         tick(10);
         chk(ENTRY_SEL, i);
         axi_rd(`BRC_STAT_OFS);
         chk(rd_q[9:0], {2'h2, 3'h0, 1'h1, 1'h0, 1'h1, i[1:0]});
         axi_rd(`BRC_CNT_OFS);
         chk(rd_q[7:0] >= lo_t[i] && rd_q[7:0] <= hi_t[i], 1'h1);
         if (i == 3)
         begin
            fb(1000);
            tick(BLK + 30);
            chk(BURST_CS_SEL, 1'h0);
         end
      end
   endtask
   task t_postpone;
      BROWNOUT <= 1'h1;
      start(150);
      axi_rd(`BRC_STAT_OFS);
      chk(rd_q[9:8], 2'h0);
      chk(ENTRY_SEL, `BRC_LVL_NONE);
      BROWNOUT <= 1'h0;
      tick(DET + 20);
      chk(ENTRY_SEL, `BRC_LVL_127);
   endtask
   task t_burst;
      start(150);
      fb(2500);
      axi_rd(`BRC_CTRL_OFS);
      chk(rd_q, 32'h1);
      axi_rd(12'h00c);
      chk(resp_q, `BRC_RESP_ERR);
      chk(rd_q, 32'h0);
      axi_wr(12'h00c, 32'h0);
      chk(resp_q, `BRC_RESP_ERR);
      axi_rd(`BRC_CTRL_OFS);
      chk(rd_q, 32'h1);
      fb(1000);
      tick(BLK - 20);
      fb(2500);
      tick(5);
      fb(1000);
      tick(BLK - 20);
      chk(BURST_CS_SEL, 1'h0);
      fb(2500);
      axi_wr(`BRC_CTRL_OFS, 32'h0);
      chk(resp_q, `BRC_RESP_OK);
      fb(1000);
      tick(BLK + 30);
      chk(BURST_CS_SEL, 1'h0);
      fb(2500);
      axi_wr(`BRC_CTRL_OFS, 32'h1);
      fb(1000);
      tick(BLK + 30);
      chk({BURST_CS_SEL, BIAS_EN, GATE_EN}, 3'h4);
      fb(3600);
      tick(10);
      chk({BURST_CS_SEL, BIAS_EN, GATE_EN}, 3'h7);
      fb(3100);
      tick(10);
      chk({BURST_CS_SEL, BIAS_EN, GATE_EN}, 3'h4);
      fb(4100);
      tick(10);
      chk({BURST_CS_SEL, BIAS_EN, GATE_EN}, 3'h3);
      fb(1000);
      tick(BLK - 20);
      chk(BURST_CS_SEL, 1'h0);
      fb(2500);
      tick(10);
   endtask
   task t_restart;
      fb(4600);
      tick(BLK + 30);
      fb(2500);
      chk({AR_ACTIVE, GATE_EN}, 2'h2);
      axi_rd(`BRC_STAT_OFS);
      chk(rd_q[7:5], {1'h0, `BRC_MODE_ODD});
      uv;
      axi_rd(`BRC_STAT_OFS);
      chk({AR_ACTIVE, GATE_EN, rd_q[7]}, 3'h5);
      uv;
      chk({AR_ACTIVE, GATE_EN, ENTRY_SEL}, {2'h1, `BRC_LVL_127});
      VCC_OVP2 <= 1'h1;
      uv;
      uv;
      chk(AR_ACTIVE, 1'h1);
      VCC_OVP2 <= 1'h0;
      uv;
      uv;
      chk(AR_ACTIVE, 1'h0);
      OVER_TEMP <= 1'h1;
      tick(10);
      axi_rd(`BRC_STAT_OFS);
      chk(rd_q[6:5], `BRC_MODE_NSW);
      uv;
      uv;
      chk({AR_ACTIVE, GATE_EN}, 2'h2);
      OVER_TEMP <= 1'h0;
      uv;
      uv;
      chk({AR_ACTIVE, GATE_EN}, 2'h1);
      EXT_PROT <= 1'h1;
      tick(10);
      axi_rd(`BRC_STAT_OFS);
      chk(rd_q[6:5], `BRC_MODE_NSW);
      EXT_PROT <= 1'h0;
      uv;
      uv;
      chk(AR_ACTIVE, 1'h0);
      UVLO_ON <= 1'h0;
      tick(10);
      axi_rd(`BRC_STAT_OFS);
      chk({AR_ACTIVE, rd_q[6:5]}, {1'h1, `BRC_MODE_NORM});
      UVLO_ON <= 1'h1;
      tick(10);
      chk({AR_ACTIVE, GATE_EN}, 2'h1);
      VCC_OVP1 <= 1'h1;
      tick(10);
      chk(AR_ACTIVE, 1'h0);
      fb(4600);
      tick(10);
      axi_rd(`BRC_STAT_OFS);
      chk({AR_ACTIVE, rd_q[6:5]}, {1'h1, `BRC_MODE_ODD});
      VCC_OVP1 <= 1'h0;
      fb(2500);
      uv;
      uv;
      chk({AR_ACTIVE, GATE_EN}, 2'h1);
   endtask
   ////////////////////////////////////////
   initial
   begin
      t_levels;
      t_postpone;
      t_burst;
      t_restart;
      test_done;
   end
endmodule
